// >>> logic/srw_top.sv
// supervisor: system reset sequencer, watchdog and power-fail warning
//
// How it works
// - kick level unchanged for the watchdog period expires it; watchdog output goes low.
// - the watchdog period must fall between its minimum and maximum bounds.
// - a floating kick input disables the watchdog; it never expires.
// - watchdog counter stays cleared while the system reset is asserted.
// - every kick edge, rising or falling, restarts the watchdog count from zero.
// - expired watchdog output stays low until the counter is cleared.
// - supply low forces the watchdog output low regardless of the counter.
// - watchdog output rises at once when supply low clears, unless expired.
// - system reset is low for the hold time and while supply is low.
// - after supply low clears, reset stays asserted for the full hold time.
// - manual reset low asserts reset; hold time counts from its release.
// - the hold time must lie between its minimum and maximum bounds.
// - watchdog expiry alone never asserts the system reset.
// - active-high reset output is the complement of the active-low one only in the variant without watchdog; otherwise it stays low.
// - power-fail warning is low while the sense input is below reference.
// - supply low during a running reset restarts at least the minimum hold.
// - watchdog counts only after reset release and with the kick driven.
`timescale 1ns/10ps
`default_nettype none

module srw_top import srw_pkg::*; #(
    parameter bit HAS_WDOG = 1'b1,
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int HOLD_TICKS = RESET_HOLD_TICKS,
    parameter int WD_TICKS = WD_PERIOD_TICKS,
    parameter bit CHECK_WINDOWS = 1'b1
)(
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic MANUAL_RESET_IN_N_I,
    input wire logic WATCHDOG_KICK_IN_I,
    input wire logic KICK_FLOATING_I,
    input wire logic POWERFAIL_SENSE_IN_I,
    output logic SYS_RESET_N_O,
    output logic SYS_RESET_O,
    output logic WATCHDOG_EXPIRED_N_O,
    output logic POWERFAIL_WARN_N_O
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************

    // counters are sized by the package; refuse what they cannot hold
    if (TICK_CYC < 2 || TICK_CYC >= (1 << TICK_W)) begin : g_bad_tick
        $error("tick divider out of range");
    end
    if (HOLD_TICKS < 1 || HOLD_TICKS >= (1 << HOLD_W)) begin : g_bad_hold
        $error("reset hold count out of range");
    end
    if (WD_TICKS < 1 || WD_TICKS >= (1 << WD_W)) begin : g_bad_wd
        $error("watchdog count out of range");
    end

    // timing windows; a shortened simulation build turns this off
    if (CHECK_WINDOWS) begin : g_windows
        localparam longint HOLD_CYC = longint'(HOLD_TICKS) * longint'(TICK_CYC);
        localparam longint WD_CYC = longint'(WD_TICKS) * longint'(TICK_CYC);
        if (HOLD_CYC < RESET_HOLD_MIN_CYC || HOLD_CYC > RESET_HOLD_MAX_CYC) begin : g_hold_win
            $error("reset hold time outside its window");
        end
        if (WD_CYC < WD_PERIOD_MIN_CYC || WD_CYC > WD_PERIOD_MAX_CYC) begin : g_wd_win
            $error("watchdog period outside its window");
        end
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    srw_in_t in_raw;
    srw_in_t in_s;

    // all status pins cross into the timebase clock first
    assign in_raw = '{
        supply_low: SUPPLY_LOW_I,
        manual_reset_in_n: MANUAL_RESET_IN_N_I,
        watchdog_kick_in: WATCHDOG_KICK_IN_I,
        kick_floating: KICK_FLOATING_I,
        powerfail_sense_in: POWERFAIL_SENSE_IN_I
    };

    srw_sync #(
        .W($bits(srw_in_t)),
        .RST_VAL(SYNC_RST_VAL)
    ) u_sync (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .d_i(in_raw),
        .q_o(in_s)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    srw_state_t s_reg;
    srw_state_t s_next;

    // power-on value: reset asserted, counters cleared
    localparam srw_state_t STATE_RST = '{
        rst_state: RS_ASSERT,
        hold_cnt: '0,
        tick_cnt: '0,
        wd_cnt: '0,
        wd_expired: 1'b0,
        kick_prev: 1'b0,
        rst_n: 1'b0,
        rst: HAS_WDOG ? 1'b0 : 1'b1,
        wdo_n: 1'b1,
        pfo_n: 1'b1
    };

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_TICKS - 1);
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TICKS - 1);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    logic tick;
    logic cause;
    logic kick_edge;
    logic wd_clear;

    always_comb begin
        s_next = s_reg;

        // a reset cause is supply low or manual reset pulled low
        cause = in_s.supply_low | ~in_s.manual_reset_in_n;

        // timebase divider; restarted while a cause is present so that
        // the hold time is exact from the moment the cause clears
        tick = (s_reg.tick_cnt == TICK_LAST);
        if (cause || tick) begin
            s_next.tick_cnt = '0;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
        end

        // reset sequencer
        unique case (s_reg.rst_state)
            RS_ASSERT: begin
                // held here as long as any cause stays active
                s_next.hold_cnt = '0;
                if (!cause) begin
                    s_next.rst_state = RS_HOLD;
                end
            end
            RS_HOLD: begin
                if (cause) begin
                    // a new cause restarts the whole hold time
                    s_next.rst_state = RS_ASSERT;
                    s_next.hold_cnt = '0;
                end else if (tick) begin
                    if (s_reg.hold_cnt == HOLD_LAST) begin
                        s_next.rst_state = RS_RUN;
                    end else begin
                        s_next.hold_cnt = s_reg.hold_cnt + 1'b1;
                    end
                end
            end
            RS_RUN: begin
                if (cause) begin
                    s_next.rst_state = RS_ASSERT;
                end
            end
        endcase

        // only the sequencer drives the reset; watchdog never does
        s_next.rst_n = (s_next.rst_state == RS_RUN);
        // complement only exists in the variant without watchdog
        s_next.rst = HAS_WDOG ? 1'b0 : ~s_next.rst_n;

        // watchdog kick edges, either direction
        kick_edge = in_s.watchdog_kick_in ^ s_reg.kick_prev;
        s_next.kick_prev = in_s.watchdog_kick_in;

        // clearing conditions: reset, floating kick, kick edge, variant
        wd_clear = ~s_reg.rst_n | in_s.kick_floating | kick_edge | ~HAS_WDOG;

        if (wd_clear) begin
            s_next.wd_cnt = '0;
            s_next.wd_expired = 1'b0;
        end else if (tick && !s_reg.wd_expired) begin
            if (s_reg.wd_cnt == WD_LAST) begin
                s_next.wd_expired = 1'b1;
            end else begin
                s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
            end
        end

        // watchdog output doubles as low-line flag; no minimum low time,
        // so it follows supply low within one clock of the synchroniser
        if (HAS_WDOG) begin
            s_next.wdo_n = ~(s_next.wd_expired | in_s.supply_low);
        end else begin
            s_next.wdo_n = 1'b1;
        end

        // power-fail comparator result passes straight through
        s_next.pfo_n = in_s.powerfail_sense_in;
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // synchronous reset; outputs come straight from this register
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign SYS_RESET_N_O = s_reg.rst_n;
    assign SYS_RESET_O = s_reg.rst;
    assign WATCHDOG_EXPIRED_N_O = s_reg.wdo_n;
    assign POWERFAIL_WARN_N_O = s_reg.pfo_n;

endmodule

`default_nettype wire

// >>> pkg/srw_pkg.sv
// constants, types and state layout shared by the supervisor design
package srw_pkg;

    // ****************************************************************
    // clock and timebase
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_US = 1000;
    // one timebase tick per millisecond
    localparam int TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;

    // ****************************************************************
    // reset hold time, nominal and window
    // ****************************************************************
    localparam int RESET_HOLD_MS = 200;
    localparam int RESET_HOLD_MIN_MS = 140;
    localparam int RESET_HOLD_MAX_MS = 280;
    localparam int RESET_HOLD_TICKS = RESET_HOLD_MS * 1000 / TICK_US;
    localparam longint RESET_HOLD_MIN_CYC = longint'(RESET_HOLD_MIN_MS) * (CLK_HZ / 1000);
    localparam longint RESET_HOLD_MAX_CYC = longint'(RESET_HOLD_MAX_MS) * (CLK_HZ / 1000);

    // ****************************************************************
    // watchdog period, nominal and window
    // ****************************************************************
    localparam int WD_PERIOD_MS = 1600;
    localparam int WD_PERIOD_MIN_MS = 1000;
    localparam int WD_PERIOD_MAX_MS = 2250;
    localparam int WD_PERIOD_TICKS = WD_PERIOD_MS * 1000 / TICK_US;
    localparam longint WD_PERIOD_MIN_CYC = longint'(WD_PERIOD_MIN_MS) * (CLK_HZ / 1000);
    localparam longint WD_PERIOD_MAX_CYC = longint'(WD_PERIOD_MAX_MS) * (CLK_HZ / 1000);

    // ****************************************************************
    // counter widths
    // ****************************************************************
    localparam int TICK_W = 16;
    localparam int HOLD_W = 12;
    localparam int WD_W = 12;

    // ****************************************************************
    // input bundle and its synchroniser reset value
    // ****************************************************************
    typedef struct packed {
        logic supply_low;
        logic manual_reset_in_n;
        logic watchdog_kick_in;
        logic kick_floating;
        logic powerfail_sense_in;
    } srw_in_t;

    // supply low and kick floating assumed until proven otherwise
    localparam srw_in_t SYNC_RST_VAL = '{
        supply_low: 1'b1,
        manual_reset_in_n: 1'b1,
        watchdog_kick_in: 1'b0,
        kick_floating: 1'b1,
        powerfail_sense_in: 1'b1
    };

    // ****************************************************************
    // reset sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        RS_ASSERT = 2'b00,
        RS_HOLD = 2'b01,
        RS_RUN = 2'b10
    } srw_rst_state_t;

    // whole state of the top module
    typedef struct packed {
        srw_rst_state_t rst_state;
        logic [HOLD_W-1:0] hold_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic [WD_W-1:0] wd_cnt;
        logic wd_expired;
        logic kick_prev;
        logic rst_n;
        logic rst;
        logic wdo_n;
        logic pfo_n;
    } srw_state_t;

endpackage

// >>> logic/srw_sync.sv
// two-flop synchroniser for a bundle of level inputs
`timescale 1ns/10ps
`default_nettype none

module srw_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RST_VAL = '0
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ****************************************************************
    // synchroniser stages
    // ****************************************************************
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// >>> testbench/srw_chk.sv
// assertion checker on the supervisor top ports
`timescale 1ns/10ps
`default_nettype none
module srw_chk #(
    parameter bit HAS_WDOG = 1'b1,
    parameter int TICK_CYC = 4,
    parameter int HOLD_TICKS = 5,
    parameter int WD_TICKS = 8
)(
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic MANUAL_RESET_IN_N_I,
    input wire logic WATCHDOG_KICK_IN_I,
    input wire logic KICK_FLOATING_I,
    input wire logic POWERFAIL_SENSE_IN_I,
    input wire logic SYS_RESET_N_O,
    input wire logic SYS_RESET_O,
    input wire logic WATCHDOG_EXPIRED_N_O,
    input wire logic POWERFAIL_WARN_N_O
);
    localparam int HC = HOLD_TICKS * TICK_CYC;
    localparam int WC = WD_TICKS * TICK_CYC;
    int cause_age;
    int kick_age;
    // ****
    // cycles since last reset cause and last watchdog clear
    // ****
    // int ages cannot wrap within one short run
    always_ff @(posedge MCLK_I) begin
        cause_age <= (RST_I || SUPPLY_LOW_I || !MANUAL_RESET_IN_N_I) ? 0 : cause_age + 1;
        kick_age <= (RST_I || KICK_FLOATING_I || !SYS_RESET_N_O ||
            WATCHDOG_KICK_IN_I != $past(WATCHDOG_KICK_IN_I)) ? 0 : kick_age + 1;
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // ****
    // properties
    // ****
    a_por_reset: assert property ($fell(RST_I) |-> !SYS_RESET_N_O)
        else $error("reset output high after power-on");
    a_mr_assert: assert property ($fell(MANUAL_RESET_IN_N_I) |-> ##[1:3] !SYS_RESET_N_O)
        else $error("manual reset not asserting");
    a_low_line: assert property (SUPPLY_LOW_I [*4] |-> !SYS_RESET_N_O && !WATCHDOG_EXPIRED_N_O)
        else $error("outputs high while supply low");
    a_hold_exact: assert property ($rose(SYS_RESET_N_O) |-> cause_age inside {[HC + 1:HC + 3]})
        else $error("reset hold length wrong");
    a_expiry_quiet: assert property ((SYS_RESET_N_O && MANUAL_RESET_IN_N_I && !SUPPLY_LOW_I) [*4]
        |=> SYS_RESET_N_O)
        else $error("reset asserted without cause");
    a_wd_period: assert property ($fell(WATCHDOG_EXPIRED_N_O) && !SUPPLY_LOW_I && kick_age > 8
        |-> kick_age inside {[WC - TICK_CYC:WC + 5]})
        else $error("watchdog period wrong");
    a_float_off: assert property ((KICK_FLOATING_I && !SUPPLY_LOW_I) [*6] |-> WATCHDOG_EXPIRED_N_O)
        else $error("watchdog low while disabled");
    a_kick_clear: assert property ($changed(WATCHDOG_KICK_IN_I) && SYS_RESET_N_O && !KICK_FLOATING_I
        && !SUPPLY_LOW_I |-> ##[2:4] WATCHDOG_EXPIRED_N_O)
        else $error("kick edge did not clear watchdog");
    a_pfo_follow: assert property (!$past(RST_I) && !$past(RST_I, 2) && !$past(RST_I, 3)
        |-> POWERFAIL_WARN_N_O == $past(POWERFAIL_SENSE_IN_I, 3))
        else $error("power-fail warning wrong");
    a_variant: assert property (SYS_RESET_O == (HAS_WDOG ? 1'b0 : !SYS_RESET_N_O))
        else $error("high reset output wrong");
    c_release: cover property ($rose(SYS_RESET_N_O));
    c_expiry: cover property ($fell(WATCHDOG_EXPIRED_N_O) && SYS_RESET_N_O);
    c_pf: cover property ($fell(POWERFAIL_WARN_N_O));
endmodule
`default_nettype wire

// >>> testbench/srw_cpu.sv
// processor-side model that toggles the watchdog kick line
`timescale 1ns/10ps
`default_nettype none
module srw_cpu #(
    parameter int GAP = 6
)(
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic rst_n_i,
    output logic kick_o
);
    int cnt = 0;
    initial kick_o = 1'b0;
    // each level held GAP cycles, far above the shortest pulse seen
    always @(posedge clk_i) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        if (en_i && rst_n_i && cnt == 0) begin
            kick_o <= #2 ~kick_o;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the supervisor top
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int TC = 4;
    localparam int HT = 5;
    localparam int WT = 8;
    // drive edge to release edge: hold time plus the two synchroniser stages
    localparam int REL = HT * TC + 2;
    logic clk = 0, rst = 1, sup = 1, mr_n = 1, flt = 1, sense = 1, kick_en = 0;
    logic kick, rst_n, rst_h, wdo_n, pfo_n;
    logic wdo_q = 1, pfo_q = 1, rst_q = 0;
    int cyc = 0, n_mismatch = 0, n_tests = 0;
    int q_rst[$];
    logic q_wdo[$];
    logic q_pfo[$];
    logic [7:0] rnd = 8'h33;
    initial begin
        forever #25 clk = ~clk;
    end
    srw_top #(.TICK_CYC(TC), .HOLD_TICKS(HT), .WD_TICKS(WT), .CHECK_WINDOWS(1'b0)) dut_u (
        .MCLK_I(clk), .RST_I(rst), .SUPPLY_LOW_I(sup), .MANUAL_RESET_IN_N_I(mr_n),
        .WATCHDOG_KICK_IN_I(kick), .KICK_FLOATING_I(flt), .POWERFAIL_SENSE_IN_I(sense),
        .SYS_RESET_N_O(rst_n), .SYS_RESET_O(rst_h), .WATCHDOG_EXPIRED_N_O(wdo_n),
        .POWERFAIL_WARN_N_O(pfo_n));
    srw_cpu cpu_u (.clk_i(clk), .en_i(kick_en), .rst_n_i(rst_n), .kick_o(kick));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk_int(input int e, input int g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // inputs always move 2 ns after the edge, after the watcher looked
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // raise a cause for len cycles; supply low also drags the watchdog line
    task automatic cause(input bit sel, input int len);
        if (sel) begin
            sup = 1;
            q_wdo.push_back(1'b0);
            q_wdo.push_back(1'b1);
        end else begin
            mr_n = 0;
        end
        step(len);
        sup = 0;
        mr_n = 1;
    endtask
    // watcher: every watchdog or power-fail output change, and each reset release, takes the oldest note of its kind
    always @(posedge clk) begin
        cyc <= cyc + 1;
        #1;
        if (rst_n === 1'b1 && rst_q !== 1'b1) begin
            chk_int(q_rst.size() > 0 ? q_rst.pop_front() : -1, cyc);
        end
        if (wdo_n !== wdo_q) begin
            chk_bit(q_wdo.size() > 0 ? q_wdo.pop_front() : 1'bx, wdo_n);
        end
        if (pfo_n !== pfo_q) begin
            chk_bit(q_pfo.size() > 0 ? q_pfo.pop_front() : 1'bx, pfo_n);
        end
        rst_q = rst_n;
        wdo_q = wdo_n;
        pfo_q = pfo_n;
    end
    // cut a hang short well past the expected run
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        step(10);
        rst = 0;
        q_wdo.push_back(1'b0);
        q_wdo.push_back(1'b1);
        step(6);
        sup = 0;
        q_rst.push_back(cyc + REL);
        step(REL + 4);
        cause(0, 3);
        q_rst.push_back(cyc + REL);
        step(REL + 4);
        cause(1, 2);
        step(8);
        cause(1, 2);
        q_rst.push_back(cyc + REL);
        step(REL + 4);
        // watchdog: expire, kick back, expire again, disable
        flt = 0;
        q_wdo.push_back(1'b0);
        step(WT * TC + 8);
        kick_en = 1;
        q_wdo.push_back(1'b1);
        step(WT * TC * 3);
        kick_en = 0;
        q_wdo.push_back(1'b0);
        step(WT * TC + 12);
        flt = 1;
        q_wdo.push_back(1'b1);
        step(WT * TC * 2);
        repeat (16) begin
            rnd = lfsr(rnd);
            if (rnd[0] !== sense) q_pfo.push_back(rnd[0]);
            sense = rnd[0];
            step(4);
        end
        step(6);
        chk_int(0, q_rst.size() + q_wdo.size() + q_pfo.size());
        summarize();
    end
endmodule
// checker defaults match the shortened bench build
bind srw_top srw_chk chk_u (.MCLK_I(MCLK_I), .RST_I(RST_I), .SUPPLY_LOW_I(SUPPLY_LOW_I),
    .MANUAL_RESET_IN_N_I(MANUAL_RESET_IN_N_I), .WATCHDOG_KICK_IN_I(WATCHDOG_KICK_IN_I),
    .KICK_FLOATING_I(KICK_FLOATING_I), .POWERFAIL_SENSE_IN_I(POWERFAIL_SENSE_IN_I),
    .SYS_RESET_N_O(SYS_RESET_N_O), .SYS_RESET_O(SYS_RESET_O),
    .WATCHDOG_EXPIRED_N_O(WATCHDOG_EXPIRED_N_O), .POWERFAIL_WARN_N_O(POWERFAIL_WARN_N_O));
`default_nettype wire
